/* hw/dfpc_top.sv */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module dfpc_top
  import dfpc_pkg::*;
#(
  parameter int unsigned FREQ_M0 = FREQ_M0_HZ,
  parameter int unsigned FREQ_M1 = FREQ_M1_HZ,
  parameter int unsigned FREQ_M2 = FREQ_M2_HZ,
  parameter int unsigned FREQ_M3 = FREQ_M3_HZ
)
(
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // fan pins
  output logic first_fan_output_out,
  output logic second_fan_output_out
);

  // slot lengths per mode, from the frequency parameters
  localparam logic [DIV_W-1:0] DIV_M0 = dfpc_slot_cycles(FREQ_M0);
  localparam logic [DIV_W-1:0] DIV_M1 = dfpc_slot_cycles(FREQ_M1);
  localparam logic [DIV_W-1:0] DIV_M2 = dfpc_slot_cycles(FREQ_M2);
  localparam logic [DIV_W-1:0] DIV_M3 = dfpc_slot_cycles(FREQ_M3);

  logic [DATA_W-1:0] fan_one_ff;
  logic [DATA_W-1:0] fan_two_ff;
  logic [DATA_W-1:0] fan_ctl_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_fan_one;
  logic [DATA_W-1:0] nxt_fan_two;
  logic [DATA_W-1:0] nxt_fan_ctl;
  logic [DATA_W-1:0] nxt_rdata;

  // address decode
  wire hit_one_w;
  wire hit_two_w;
  wire hit_ctl_w;
  wire hit_stat_w;
  wire wr_one_w;
  wire wr_two_w;
  wire wr_ctl_w;

  assign hit_one_w = (reg_addr_in == FAN_ONE_OFS);
  assign hit_two_w = (reg_addr_in == FAN_TWO_OFS);
  assign hit_ctl_w = (reg_addr_in == FAN_CTL_OFS);
  assign hit_stat_w = (reg_addr_in == FAN_STAT_OFS);
  assign wr_one_w = reg_wr_in & hit_one_w;
  assign wr_two_w = reg_wr_in & hit_two_w;
  assign wr_ctl_w = reg_wr_in & hit_ctl_w;

  assign nxt_fan_one = wr_one_w ? reg_wdata_in : fan_one_ff;
  assign nxt_fan_two = wr_two_w ? reg_wdata_in : fan_two_ff;
  // divisor bits [7:4] are kept for software only
  assign nxt_fan_ctl = wr_ctl_w ? reg_wdata_in : fan_ctl_ff;

  // channel settings
  wire force_one_w;
  wire force_two_w;
  wire [DUTY_W-1:0] duty_one_w;
  wire [DUTY_W-1:0] duty_two_w;

  assign force_one_w = fan_one_ff[FORCE_BIT];
  assign force_two_w = fan_two_ff[FORCE_BIT];
  assign duty_one_w = fan_one_ff[DUTY_LSB +: DUTY_W];
  assign duty_two_w = fan_two_ff[DUTY_LSB +: DUTY_W];

  // rate selection: {clock select, clock source} picks a mode
  wire [1:0] mode_one_w;
  wire [1:0] mode_two_w;
  wire mul_one_w;
  wire mul_two_w;
  wire [DIV_W-1:0] base_one_w;
  wire [DIV_W-1:0] base_two_w;
  wire [DIV_W-1:0] div_one_w;
  wire [DIV_W-1:0] div_two_w;

  assign mode_one_w = {fan_one_ff[CLK_SEL_BIT], fan_ctl_ff[SRC_ONE_BIT]};
  assign mode_two_w = {fan_two_ff[CLK_SEL_BIT], fan_ctl_ff[SRC_TWO_BIT]};
  assign mul_one_w = fan_ctl_ff[MUL_ONE_BIT];
  assign mul_two_w = fan_ctl_ff[MUL_TWO_BIT];

  function automatic logic [DIV_W-1:0] pick_div(logic [1:0] mode);
    logic [DIV_W-1:0] d;
    case (mode)
      2'h0: d = DIV_M0;
      2'h1: d = DIV_M1;
      2'h2: d = DIV_M2;
      default: d = DIV_M3;
    endcase
    return d;
  endfunction : pick_div

  // halving the slot doubles the rate; a one-cycle slot cannot halve
  function automatic logic [DIV_W-1:0] apply_mul(logic [DIV_W-1:0] base,
                                                 logic mul);
    logic [DIV_W-1:0] d;
    d = mul ? (base >> 1) : base;
    if (d == '0)
      d = {{(DIV_W-1){1'b0}}, 1'b1};
    return d;
  endfunction : apply_mul

  assign base_one_w = pick_div(mode_one_w);
  assign base_two_w = pick_div(mode_two_w);
  assign div_one_w = apply_mul(base_one_w, mul_one_w);
  assign div_two_w = apply_mul(base_two_w, mul_two_w);

  // slot ticks
  wire tick_one_w;
  wire tick_two_w;

  dfpc_prescaler u_pre_one (
    .core_clk_in (core_clk_in),
    .rst_b_in (rst_b_in),
    .clk_en_in (clk_en_in),
    .div_in (div_one_w),
    .tick_out (tick_one_w)
  );

  dfpc_prescaler u_pre_two (
    .core_clk_in (core_clk_in),
    .rst_b_in (rst_b_in),
    .clk_en_in (clk_en_in),
    .div_in (div_two_w),
    .tick_out (tick_two_w)
  );

  // waveform channels
  wire [DUTY_W-1:0] slot_one_w;
  wire [DUTY_W-1:0] slot_two_w;
  wire [DUTY_W-1:0] live_one_w;
  wire [DUTY_W-1:0] live_two_w;

  dfpc_pwm_chan u_chan_one (
    .core_clk_in (core_clk_in),
    .rst_b_in (rst_b_in),
    .clk_en_in (clk_en_in),
    .tick_in (tick_one_w),
    .force_in (force_one_w),
    .duty_in (duty_one_w),
    .pin_out (first_fan_output_out),
    .slot_out (slot_one_w),
    .duty_live_out (live_one_w)
  );

  dfpc_pwm_chan u_chan_two (
    .core_clk_in (core_clk_in),
    .rst_b_in (rst_b_in),
    .clk_en_in (clk_en_in),
    .tick_in (tick_two_w),
    .force_in (force_two_w),
    .duty_in (duty_two_w),
    .pin_out (second_fan_output_out),
    .slot_out (slot_two_w),
    .duty_live_out (live_two_w)
  );

  // read path: data valid only in the cycle after the strobe
  wire [DATA_W-1:0] stat_w;
  wire [DATA_W-1:0] rd_mux_w;

  assign stat_w = {slot_one_w, second_fan_output_out, first_fan_output_out};
  assign rd_mux_w = hit_one_w ? fan_one_ff :
                    hit_two_w ? fan_two_ff :
                    hit_ctl_w ? fan_ctl_ff :
                    hit_stat_w ? stat_w : RDATA_RST;
  assign nxt_rdata = reg_rd_in ? rd_mux_w : RDATA_RST;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      fan_one_ff <= FAN_ONE_RST;
      fan_two_ff <= FAN_TWO_RST;
      fan_ctl_ff <= FAN_CTL_RST;
      rdata_ff <= RDATA_RST;
    end
    else if (clk_en_in)
    begin
      fan_one_ff <= nxt_fan_one;
      fan_two_ff <= nxt_fan_two;
      fan_ctl_ff <= nxt_fan_ctl;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;

  // helper: ce cycles between slot ticks of channel one
  logic [DIV_W-1:0] gap_one_ff;
  logic [DIV_W-1:0] divq_one_ff;
  logic gap_ok_one_ff;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      gap_one_ff <= '0;
      divq_one_ff <= '0;
      gap_ok_one_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (div_one_w != divq_one_ff)
      begin
        gap_one_ff <= '0;
        divq_one_ff <= div_one_w;
        gap_ok_one_ff <= 1'b0;
      end
      else if (tick_one_w)
      begin
        gap_one_ff <= '0;
        gap_ok_one_ff <= 1'b1;
      end
      else
        gap_one_ff <= gap_one_ff + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence wr_force_one_s;
    clk_en_in && reg_wr_in && hit_one_w && reg_wdata_in[FORCE_BIT];
  endsequence

  sequence pin_one_high_s;
    clk_en_in ##1 first_fan_output_out;
  endsequence

  // a rewrite right after the force must not hide the first forced cycle
  force_one_a:
    assert property (wr_force_one_s |=> pin_one_high_s)
    else $error("first fan pin not high while forced");

  force_two_a:
    assert property (clk_en_in && force_two_w |=> second_fan_output_out)
    else $error("second fan pin not high while forced");

  zero_low_a:
    assert property (clk_en_in && !force_one_w && live_one_w == 6'h00
                     |=> !first_fan_output_out)
    else $error("zero duty drove first pin high");

  half_high_a:
    assert property (clk_en_in && !force_two_w && live_two_w == 6'h20
                     && slot_two_w == 6'h1F |=> second_fan_output_out)
    else $error("half duty low in slot 31");

  half_low_a:
    assert property (clk_en_in && !force_two_w && live_two_w == 6'h20
                     && slot_two_w == 6'h20 |=> !second_fan_output_out)
    else $error("half duty high in slot 32");

  full_gap_a:
    assert property (clk_en_in && !force_one_w && live_one_w == 6'h3F
                     && slot_one_w == 6'h3F |=> !first_fan_output_out)
    else $error("all-ones duty missed its low slot");

  slot_step_a:
    assert property (tick_one_w |=> slot_one_w == $past(slot_one_w) + 6'h01)
    else $error("slot counter did not advance on tick");

  tick_gap_a:
    assert property (tick_one_w && gap_ok_one_ff && div_one_w == divq_one_ff
                     |-> gap_one_ff + 16'h0001 == div_one_w)
    else $error("slot length does not match selected rate");

  mul_two_a:
    assert property (mul_two_w && base_two_w > 16'h0001
                     |-> div_two_w == (base_two_w >> 1))
    else $error("second multiplier did not halve slot");

  mul_one_a:
    assert property (mul_one_w && base_one_w > 16'h0001
                     |-> div_one_w == (base_one_w >> 1))
    else $error("first multiplier did not halve slot");

  zero_low_two_a:
    assert property (clk_en_in && !force_two_w && live_two_w == 6'h00
                     |=> !second_fan_output_out)
    else $error("zero duty drove second pin high");

  full_gap_two_a:
    assert property (clk_en_in && !force_two_w && live_two_w == 6'h3F
                     && slot_two_w == 6'h3F |=> !second_fan_output_out)
    else $error("second all-ones duty missed its low slot");

endmodule : dfpc_top

/* hw/dfpc_pkg.sv */
package dfpc_pkg;

  // core clock and waveform shape
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOTS = 64;
  localparam int DUTY_W = 6;
  localparam int DIV_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] FAN_ONE_OFS = 8'h56;
  localparam logic [7:0] FAN_TWO_OFS = 8'h57;
  localparam logic [7:0] FAN_CTL_OFS = 8'h58;
  localparam logic [7:0] FAN_STAT_OFS = 8'h59;

  // values after reset, and the last slot of a period
  localparam logic [7:0] FAN_ONE_RST = 8'h00;
  localparam logic [7:0] FAN_TWO_RST = 8'h00;
  localparam logic [7:0] FAN_CTL_RST = 8'h50;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [5:0] SLOT_LAST = 6'h3F;

  // channel register fields
  localparam int FORCE_BIT = 0;
  localparam int DUTY_LSB = 1;
  localparam int CLK_SEL_BIT = 7;

  // shared fan control register fields
  localparam int SRC_ONE_BIT = 0;
  localparam int SRC_TWO_BIT = 1;
  localparam int MUL_ONE_BIT = 2;
  localparam int MUL_TWO_BIT = 3;

  // status register fields
  localparam int STAT_ONE_BIT = 0;
  localparam int STAT_TWO_BIT = 1;
  localparam int STAT_SLOT_LSB = 2;

  // default waveform frequency per {clock select, clock source}
  localparam int unsigned FREQ_M0_HZ = 250;
  localparam int unsigned FREQ_M1_HZ = 500;
  localparam int unsigned FREQ_M2_HZ = 1000;
  localparam int unsigned FREQ_M3_HZ = 2000;

  // core cycles per slot, rounded down, never below one
  function automatic logic [DIV_W-1:0] dfpc_slot_cycles(int unsigned hz);
    int unsigned cyc;
    cyc = CLK_HZ / (hz * SLOTS);
    if (cyc < 1)
      cyc = 1;
    return cyc[DIV_W-1:0];
  endfunction : dfpc_slot_cycles

endpackage : dfpc_pkg

/* hw/dfpc_prescaler.sv */
`timescale 1ns/1ps
module dfpc_prescaler
  import dfpc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // slot length in core cycles
  input wire logic [DIV_W-1:0] div_in,
  // one pulse per slot
  output logic tick_out
);

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;
  wire last_w;

  // >= so a shrinking divisor never lets the count run away
  assign last_w = (cnt_ff >= div_in - {{(DIV_W-1){1'b0}}, 1'b1});
  assign tick_out = clk_en_in & last_w;
  assign nxt_cnt = last_w ? '0 : cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
      cnt_ff <= '0;
    else if (clk_en_in)
      cnt_ff <= nxt_cnt;
  end

endmodule : dfpc_prescaler

/* hw/dfpc_pwm_chan.sv */
`timescale 1ns/1ps
module dfpc_pwm_chan
  import dfpc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // slot pulse and setting
  input wire logic tick_in,
  input wire logic force_in,
  input wire logic [DUTY_W-1:0] duty_in,
  // pin and observed state
  output logic pin_out,
  output logic [DUTY_W-1:0] slot_out,
  output logic [DUTY_W-1:0] duty_live_out
);

  logic [DUTY_W-1:0] slot_ff;
  logic [DUTY_W-1:0] duty_ff;
  logic pin_ff;
  logic [DUTY_W-1:0] nxt_slot;
  logic [DUTY_W-1:0] nxt_duty;
  logic nxt_pin;
  wire wrap_w;

  assign wrap_w = tick_in & (slot_ff == SLOT_LAST);
  assign nxt_slot = tick_in ? slot_ff + {{(DUTY_W-1){1'b0}}, 1'b1} : slot_ff;
  // new duty only at a period boundary, so no runt pulses on a rewrite
  assign nxt_duty = wrap_w ? duty_in : duty_ff;
  // high for duty slots of 64; force overrides
  assign nxt_pin = force_in | (slot_ff < duty_ff);

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      slot_ff <= '0;
      duty_ff <= '0;
      pin_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      slot_ff <= nxt_slot;
      duty_ff <= nxt_duty;
      pin_ff <= nxt_pin;
    end
  end

  assign pin_out = pin_ff;
  assign slot_out = slot_ff;
  assign duty_live_out = duty_ff;

endmodule : dfpc_pwm_chan

/* dv/dfpc_fan_model.sv */
`timescale 1ns/1ps
module dfpc_fan_model
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // drive pin seen by the fan
  input wire logic pin_in,
  // last whole period, rise to rise
  output logic [15:0] period_out,
  output logic [15:0] high_out,
  output logic [15:0] rises_out
);
  logic pin_q_ff;
  logic [15:0] cnt_ff;
  logic [15:0] hi_ff;

  // a fan only feels edges, so time is counted rise to rise
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      pin_q_ff <= 1'b0;
      cnt_ff <= 16'h0000;
      hi_ff <= 16'h0000;
      period_out <= 16'h0000;
      high_out <= 16'h0000;
      rises_out <= 16'h0000;
    end
    else
    begin
      pin_q_ff <= pin_in;
      if (pin_in && !pin_q_ff)
      begin
        period_out <= cnt_ff;
        high_out <= hi_ff;
        rises_out <= rises_out + 16'h0001;
        cnt_ff <= 16'h0001;
        hi_ff <= 16'h0001;
      end
      else
      begin
        cnt_ff <= cnt_ff + 16'h0001;
        hi_ff <= hi_ff + {15'h0000, pin_in};
      end
    end
  end
endmodule : dfpc_fan_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench
  import dfpc_pkg::*;
;
  // high rates keep periods short: slots of 7, 3, 2 and 1 cycles
  localparam int unsigned F0 = 100000;
  localparam int unsigned F1 = 200000;
  localparam int unsigned F2 = 390625;
  localparam int unsigned F3 = 781250;
  logic core_clk_in;
  logic rst_b_in;
  logic clk_en_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [DATA_W-1:0] reg_rdata_out;
  logic first_fan_output_out;
  logic second_fan_output_out;
  logic [15:0] per1, hi1, rise1, per2, hi2, rise2;
  int fail_count;
  int total_checks;
  int cycles;

  dfpc_top #(.FREQ_M0(F0), .FREQ_M1(F1), .FREQ_M2(F2), .FREQ_M3(F3))
  dfpc_top_inst (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .first_fan_output_out(first_fan_output_out),
    .second_fan_output_out(second_fan_output_out));
  dfpc_fan_model dfpc_fan_model_inst (.core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), .pin_in(first_fan_output_out),
    .period_out(per1), .high_out(hi1), .rises_out(rise1));
  dfpc_fan_model dfpc_fan_model_two_inst (.core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), .pin_in(second_fan_output_out),
    .period_out(per2), .high_out(hi2), .rises_out(rise2));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t byte %0h exp %0h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_count(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t count %0d exp %0d", $time, got, exp);
    end
  endtask : chk_count

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk_byte(reg_rdata_out, e);
    @(posedge core_clk_in);
    #1;
    chk_byte(reg_rdata_out, RDATA_RST);
  endtask : rd_chk

  // cycles in n clocks where the pin is not at lvl
  task automatic pin_off(input int ch, input logic lvl, input int n);
    int bad;
    bad = 0;
    repeat (n)
    begin
      @(posedge core_clk_in);
      #1;
      if ((ch ? second_fan_output_out : first_fan_output_out) !== lvl)
        bad++;
    end
    chk_count(16'(bad), 16'h0000);
  endtask : pin_off

  function automatic int exp_slot(input int m, input int mul);
    int unsigned hz;
    int unsigned c;
    hz = (m == 0) ? F0 : (m == 1) ? F1 : (m == 2) ? F2 : F3;
    c = CLK_HZ / (hz * SLOTS);
    if (mul != 0)
      c = c / 2;
    return (c < 1) ? 1 : c;
  endfunction : exp_slot

  // third rise closes a clean period after any setting change
  task automatic measure(input int ch, input int slot, input int n);
    logic [15:0] r0;
    int k;
    r0 = ch ? rise2 : rise1;
    k = 0;
    while (16'((ch ? rise2 : rise1) - r0) < 16'h0003 && k < 4000)
    begin
      @(posedge core_clk_in);
      k++;
    end
    #1;
    if (k >= 4000)
    begin
      fail_count++;
      $display("MISMATCH t=%0t no clean period on channel %0d", $time, ch);
      report_and_stop();
    end
    else
    begin
      chk_count(ch ? per2 : per1, 16'(SLOTS * slot));
      chk_count(ch ? hi2 : hi1, 16'(n * slot));
    end
  endtask : measure

  task automatic t_reset();
    rd_chk(FAN_ONE_OFS, FAN_ONE_RST);
    rd_chk(FAN_TWO_OFS, FAN_TWO_RST);
    rd_chk(FAN_CTL_OFS, 8'h50);
    wr(8'hA0, 8'h5A);
    rd_chk(8'hA0, 8'h00);
    pin_off(0, 1'b0, 20);
    pin_off(1, 1'b0, 20);
    $display("reset test done");
  endtask : t_reset

  task automatic t_enable();
    @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    wr(FAN_TWO_OFS, 8'h01);
    clk_en_in <= 1'b1;
    rd_chk(FAN_TWO_OFS, 8'h00);
    pin_off(1, 1'b0, 10);
    $display("enable test done");
  endtask : t_enable

  task automatic t_force(input int ch);
    wr(8'h56 + 8'(ch), 8'hC1);
    @(posedge core_clk_in);
    pin_off(ch, 1'b1, 200);
    rd_chk(8'h56 + 8'(ch), 8'hC1);
    @(posedge core_clk_in);
    reg_addr_in <= FAN_STAT_OFS;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk_byte(reg_rdata_out & (8'h01 << ch), 8'h01 << ch);
    wr(8'h56 + 8'(ch), 8'hC0);
    measure(ch, 1, 32);
    $display("force test done");
  endtask : t_force

  task automatic t_duty();
    int d[4] = '{1, 5, 32, 63};
    for (int ch = 0; ch < 2; ch++)
    begin
      foreach (d[i])
      begin
        wr(8'h56 + 8'(ch), 8'h80 | 8'(d[i] << 1));
        measure(ch, 1, d[i]);
      end
      wr(8'h56 + 8'(ch), 8'h80);
      repeat (200) @(posedge core_clk_in);
      pin_off(ch, 1'b0, 128);
    end
    $display("duty test done");
  endtask : t_duty

  task automatic t_rate();
    for (int ch = 0; ch < 2; ch++)
    begin
      for (int m = 0; m < 4; m++)
      begin
        for (int mul = 0; mul < 2; mul++)
        begin
          wr(FAN_CTL_OFS, 8'h50 | 8'((m % 2) << ch) | 8'(mul << (2 + ch)));
          wr(8'h56 + 8'(ch), 8'(((m / 2) << 7) | 8'h40));
          measure(ch, exp_slot(m, mul), 32);
        end
      end
    end
    $display("rate test done");
  endtask : t_rate

  task automatic t_second_reset();
    wr(FAN_ONE_OFS, 8'hFF);
    rst_b_in <= 1'b0;
    @(posedge core_clk_in);
    @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    rd_chk(FAN_ONE_OFS, 8'h00);
    rd_chk(FAN_CTL_OFS, 8'h50);
    pin_off(0, 1'b0, 20);
    $display("second reset test done");
  endtask : t_second_reset

  initial
  begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  // generous ceiling over the roughly 10000 cycles of the run
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  initial
  begin
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    rst_b_in = 1'b0;
    clk_en_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_enable();
    wr(FAN_CTL_OFS, 8'h53);
    t_force(0);
    t_force(1);
    t_duty();
    t_rate();
    t_second_reset();
    report_and_stop();
  end
endmodule : testbench
